/* line_event_pkg.sv */
// Package for the per-channel line event interrupt mask block.
// Assumes an 8-bit register port with byte addresses and four channels.
package line_event_pkg;
  localparam int CHANNELS = 4;
  localparam logic [7:0] CHANNEL_STRIDE = 8'h40;
  localparam logic [7:0] STATUS_EVENT_MASK_OFS = 8'h11;
  localparam logic [7:0] ERROR_EVENT_MASK_OFS = 8'h12;
  localparam logic [7:0] EVENT_EDGE_SELECT_OFS = 8'h13;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] EDGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_OFS_MASK = 8'h3f;

  // Bit positions of the line status events, shared by mask and edge select.
  localparam int EQUALIZER_RANGE_BIT = 7;
  localparam int LOOP_ACTIVATE_CODE_BIT = 6;
  localparam int LOOP_DEACTIVATE_CODE_BIT = 5;
  localparam int PATTERN_SYNC_BIT = 4;
  localparam int TX_CLOCK_LOSS_BIT = 3;
  localparam int DRIVER_FAULT_BIT = 2;
  localparam int ALARM_INDICATION_BIT = 1;
  localparam int SIGNAL_LOSS_BIT = 0;

  // Bit positions of the error and counter events.
  localparam int CONVERTER_OVERFLOW_BIT = 7;
  localparam int JITTER_BUFFER_OVERFLOW_BIT = 6;
  localparam int JITTER_BUFFER_UNDERFLOW_BIT = 5;
  localparam int PATTERN_ERROR_BIT = 4;
  localparam int EXCESS_ZEROS_BIT = 3;
  localparam int CODE_VIOLATION_BIT = 2;
  localparam int SECOND_TIMER_BIT = 1;
  localparam int COUNTER_OVERFLOW_BIT = 0;

  typedef struct packed {
    logic [7:0] status_event_mask;
    logic [7:0] error_event_mask;
    logic [7:0] event_edge_select;
  } channel_regs_s;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

/* line_event_interrupt_mask.sv */
// Per-channel interrupt masks and trigger edge selection for four line channels.
// Assumes status and error inputs are synchronous to i_clk; an error event
// input is a one-cycle pulse from its detector.
// Operation
// - A line status event interrupt is enabled when its mask bit is 0 and suppressed when 1.
// - Every mask bit of both mask registers resets to 1.
// - The second mask register masks the eight error and counter events, 0 enabling each.
// - With edge select 0 a status event is raised only on a 0 to 1 status change.
// - With edge select 1 a status event is raised on any status change.
// - The edge select register follows the first mask bit order and resets to 0.
// - Each channel has its own register copies at offsets 11H, 12H, 13H plus 40H per channel.
// - Status events qualify from the real-time status bit; status and error events interrupt only while unmasked.
`timescale 1ns/1ps
`default_nettype none
module line_event_interrupt_mask #(
  parameter int CHANNELS = line_event_pkg::CHANNELS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [CHANNELS-1:0][7:0] i_line_status_word,
  input wire logic [CHANNELS-1:0][7:0] i_error_event,
  input wire logic [CHANNELS-1:0] i_status_service,
  input wire logic [CHANNELS-1:0] i_error_service,
  output logic [CHANNELS-1:0][7:0] o_status_pending,
  output logic [CHANNELS-1:0][7:0] o_error_pending,
  output logic o_irq
);
  line_event_pkg::channel_regs_s [CHANNELS-1:0] regs_reg, regs_next;
  logic [CHANNELS-1:0][7:0] status_prev_reg, status_prev_next;
  logic [CHANNELS-1:0][7:0] status_pend_reg, status_pend_next;
  logic [CHANNELS-1:0][7:0] error_pend_reg, error_pend_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  line_event_pkg::reg_req_s req;

  assign req = '{write: i_reg_write, read: i_reg_read, addr: i_reg_addr, wdata: i_reg_wdata};

  // Channel number sits in address bits 7:6, the register in bits 5:0.
  function automatic logic [1:0] chan_of(input logic [7:0] addr);
    chan_of = addr[7:6];
  endfunction

  function automatic logic [7:0] local_of(input logic [7:0] addr);
    local_of = addr & line_event_pkg::CHANNEL_OFS_MASK;
  endfunction

  // True when the address selects one of the implemented channels. With the channel
  // in two address bits, a larger channel count would need a wider address port.
  function automatic logic chan_hit(input logic [7:0] addr);
    chan_hit = int'(chan_of(addr)) < CHANNELS;
  endfunction

  // Rising changes always qualify; falling ones only where the select bit is 1.
  function automatic logic [7:0] edge_events(input logic [7:0] now_word,
      input logic [7:0] prev_word, input logic [7:0] both_edges);
    edge_events = (now_word & ~prev_word)
      | (~now_word & prev_word & both_edges);
  endfunction

  // A pending bit reaches the request only while its mask bit is 0.
  function automatic logic [7:0] unmasked(input logic [7:0] pend, input logic [7:0] mask);
    unmasked = pend & ~mask;
  endfunction

  // The clear is applied before the new events are added, so an event that arrives
  // together with its service pulse is kept rather than lost.
  function automatic logic [7:0] sticky(input logic [7:0] pend, input logic clear,
      input logic [7:0] set);
    sticky = (clear ? 8'h00 : pend) | set;
  endfunction

  // Register file: one write port serves the copies of every channel.
  always_comb begin
    regs_next = regs_reg;
    if (req.write && chan_hit(req.addr)) begin
      case (local_of(req.addr))
        line_event_pkg::STATUS_EVENT_MASK_OFS: begin
          regs_next[chan_of(req.addr)].status_event_mask = req.wdata;
        end
        line_event_pkg::ERROR_EVENT_MASK_OFS: begin
          regs_next[chan_of(req.addr)].error_event_mask = req.wdata;
        end
        line_event_pkg::EVENT_EDGE_SELECT_OFS: begin
          regs_next[chan_of(req.addr)].event_edge_select = req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        regs_reg[c].status_event_mask <= line_event_pkg::MASK_RESET;
        regs_reg[c].error_event_mask <= line_event_pkg::MASK_RESET;
        regs_reg[c].event_edge_select <= line_event_pkg::EDGE_SELECT_RESET;
      end
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Reads are registered; the word stands until the next read strobe, and
  // offsets that hold no register read as zero so software sees a clean value.
  always_comb begin
    rdata_next = rdata_reg;
    if (req.read) begin
      rdata_next = 8'h00;
      if (chan_hit(req.addr)) begin
        case (local_of(req.addr))
          line_event_pkg::STATUS_EVENT_MASK_OFS: begin
            rdata_next = regs_reg[chan_of(req.addr)].status_event_mask;
          end
          line_event_pkg::ERROR_EVENT_MASK_OFS: begin
            rdata_next = regs_reg[chan_of(req.addr)].error_event_mask;
          end
          line_event_pkg::EVENT_EDGE_SELECT_OFS: begin
            rdata_next = regs_reg[chan_of(req.addr)].event_edge_select;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // The copy restarts at zero, so a status bit that is already high at reset
  // release counts as a rising change on the first edge.
  always_comb begin
    status_prev_next = i_line_status_word;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        status_prev_reg[c] <= 8'h00;
      end
    end else begin
      status_prev_reg <= status_prev_next;
    end
  end

  // Status events compare each real-time word with its copy from the previous cycle.
  always_comb begin
    status_pend_next = status_pend_reg;
    for (int c = 0; c < CHANNELS; c++) begin
      status_pend_next[c] = sticky(status_pend_reg[c], i_status_service[c],
        edge_events(i_line_status_word[c], status_prev_reg[c],
        regs_reg[c].event_edge_select));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        status_pend_reg[c] <= 8'h00;
      end
    end else begin
      status_pend_reg <= status_pend_next;
    end
  end

  // Error events arrive as pulses from their detectors and are latched directly;
  // a level held high keeps setting the pending bit every cycle.
  always_comb begin
    error_pend_next = error_pend_reg;
    for (int c = 0; c < CHANNELS; c++) begin
      error_pend_next[c] = sticky(error_pend_reg[c], i_error_service[c], i_error_event[c]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        error_pend_reg[c] <= 8'h00;
      end
    end else begin
      error_pend_reg <= error_pend_next;
    end
  end

  // Pending bits latch even while masked; the mask gates only the request, so
  // clearing a mask bit later raises the request for an event already seen.
  always_comb begin
    logic [7:0] qual;
    qual = 8'h00;
    irq_next = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      qual = unmasked(status_pend_reg[c], regs_reg[c].status_event_mask)
        | unmasked(error_pend_reg[c], regs_reg[c].error_event_mask);
      irq_next = irq_next | (|qual);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_status_pending = status_pend_reg;
  assign o_error_pending = error_pend_reg;
  assign o_irq = irq_reg;
endmodule
`default_nettype wire

/* line_event_checker.sv */
// Assertions on the ports of line_event_interrupt_mask, bound to its instances.
// Status clear and sticky checks watch channel 0, the rising-edge check all channels; error checks watch channel 2.
`timescale 1ns/1ps
`default_nettype none
module line_event_checker #(
  parameter int CHANNELS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [CHANNELS-1:0][7:0] i_line_status_word,
  input wire logic [CHANNELS-1:0][7:0] i_error_event,
  input wire logic [CHANNELS-1:0] i_status_service,
  input wire logic [CHANNELS-1:0] i_error_service,
  input wire logic [CHANNELS-1:0][7:0] o_status_pending,
  input wire logic [CHANNELS-1:0][7:0] o_error_pending,
  input wire logic o_irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_rise_pend: assert property (1 |=>
    ((~o_status_pending & $past(i_line_status_word) & ~$past(i_line_status_word, 2)) == '0))
    else $error("rising status not latched");
  // The first edge after reset is skipped: the held status copy restarts at zero there.
  a_stat_clear: assert property ($past(i_rst_n) && i_status_service[0] &&
    $stable(i_line_status_word[0]) |=> o_status_pending[0] == 8'h00)
    else $error("status pending not cleared");
  a_pend_sticky: assert property (!i_status_service[0] |=>
    (~o_status_pending[0] & $past(o_status_pending[0])) == 8'h00)
    else $error("status pending lost");
  a_err_latch: assert property (1 |=>
    (~o_error_pending[2] & $past(i_error_event[2])) == 8'h00)
    else $error("error event not latched");
  a_err_clear: assert property (i_error_service[2] && i_error_event[2] == 8'h00
    |=> o_error_pending[2] == 8'h00) else $error("error pending not cleared");
  a_rdata_hold: assert property (!i_reg_read |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_reg_read &&
    !(i_reg_addr[5:0] inside {6'h11, 6'h12, 6'h13}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_idle: assert property (o_status_pending == '0 && o_error_pending == '0
    |=> !o_irq) else $error("request without pending event");
  c_irq: cover property (o_irq);
  c_svc: cover property (i_status_service[0]);
  c_read: cover property (i_reg_read);
endmodule
bind line_event_interrupt_mask line_event_checker #(.CHANNELS(CHANNELS)) chk_u (.*);
`default_nettype wire

/* tb_line_event_interrupt_mask.sv */
// Self-checking bench for line_event_interrupt_mask, four channels.
// Inputs change at the falling edge; the checker is attached by bind.
`timescale 1ns/1ps
`default_nettype none
module tb_line_event_interrupt_mask;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
  logic [3:0][7:0] st = '0, ev = '0, sp, ep;
  logic [3:0] ss = '0, es = '0;
  int n_errors = 0, check_count = 0;
  // Row: write flag, address, write data, expected read back.
  logic [24:0] rows [7] = '{{1'b0, 8'hd1, 8'h00, 8'hff}, {1'b0, 8'h92, 8'h00, 8'hff},
    {1'b0, 8'h53, 8'h00, 8'h00}, {1'b1, 8'h11, 8'hfe, 8'hfe}, {1'b0, 8'h51, 8'h00, 8'hff},
    {1'b1, 8'hd3, 8'hc3, 8'hc3}, {1'b1, 8'h20, 8'h77, 8'h00}};
  line_event_interrupt_mask dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_reg_write(wr),
    .i_reg_read(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .i_line_status_word(st), .i_error_event(ev), .i_status_service(ss),
    .i_error_service(es), .o_status_pending(sp), .o_error_pending(ep), .o_irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Each access ends with an idle edge so that the next strobe never rises in
  // the same time step in which this one fell.
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    wr = 1;
    addr = a;
    wd = d;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  task automatic rreg(logic [7:0] a);
    rd = 1;
    addr = a;
    cyc(1);
    rd = 0;
    v = rdata;
    cyc(1);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    cyc(10);
    rst_n = 1;
    foreach (rows[i]) begin
      if (rows[i][24]) wreg(rows[i][23:16], rows[i][15:8]);
      rreg(rows[i][23:16]);
      chk("register", rows[i][7:0], v);
    end
    st[0] = 8'h80;
    cyc(2);
    chk("masked pending", 8'h80, sp[0]);
    chk("masked irq", 8'h00, {7'h0, irq});
    st[0] = 8'h81;
    cyc(2);
    chk("unmasked irq", 8'h01, {7'h0, irq});
    ss[0] = 1;
    cyc(1);
    ss[0] = 0;
    st[0] = 8'h00;
    cyc(2);
    chk("fall ignored", 8'h00, sp[0]);
    chk("irq after service", 8'h00, {7'h0, irq});
    wreg(8'h13, 8'h01);
    st[0] = 8'h01;
    cyc(2);
    ss[0] = 1;
    cyc(1);
    ss[0] = 0;
    st[0] = 8'h00;
    cyc(2);
    chk("fall event", 8'h01, sp[0]);
    chk("fall irq", 8'h01, {7'h0, irq});
    // The error event meets its own service pulse: the event must survive.
    ev[2] = 8'h01;
    es[2] = 1;
    ss[0] = 1;
    cyc(1);
    ev[2] = 8'h00;
    es[2] = 0;
    ss[0] = 0;
    cyc(2);
    chk("error pending", 8'h01, ep[2]);
    chk("error masked", 8'h00, {7'h0, irq});
    wreg(8'h92, 8'hfe);
    cyc(2);
    chk("error unmasked", 8'h01, {7'h0, irq});
    es[2] = 1;
    cyc(1);
    es[2] = 0;
    cyc(2);
    chk("error cleared", 8'h00, {7'h0, irq});
    st[0] = 8'h01;
    ss[0] = 1;
    cyc(1);
    ss[0] = 0;
    cyc(1);
    chk("status set wins", 8'h01, sp[0]);
    rst_n = 0;
    cyc(1);
    rst_n = 1;
    rreg(8'h92);
    chk("mask after reset", 8'hff, v);
    chk("irq after reset", 8'h00, {7'h0, irq});
    final_report();
  end
endmodule
`default_nettype wire
